// *** qpot_cfg.svh ***
/*
 * Constants of the quad wiper serial control block: word layout,
 * reset codes and serial timing.
 * Assumes a 50 MHz system clock; included by the package and the latch and top modules.
 */
`ifndef QPOT_CFG_SVH
`define QPOT_CFG_SVH

// Word layout
`define QPOT_WORD_BITS      8
`define QPOT_CODE_BITS      6
`define QPOT_CHANNELS       4
`define QPOT_ADDR_HI_POS    7
`define QPOT_ADDR_LO_POS    6
`define QPOT_CODE_MSB_POS   5

// Reset values
`define QPOT_MIDSCALE_CODE  6'h20
`define QPOT_WORD_RESET     8'h00

// Timing
`define QPOT_CLK_PERIOD_NS      20
`define QPOT_SCLK_MIN_PERIOD_NS 100
`define QPOT_SCLK_MIN_CYCLES \
   ((`QPOT_SCLK_MIN_PERIOD_NS + `QPOT_CLK_PERIOD_NS - 1) \
    / `QPOT_CLK_PERIOD_NS)

`endif

// *** qpot_edge.sv ***
/*
 * Edge finder for one sampled input level.
 * Assumes the input is synchronous to i_clk.
 */
`timescale 1ns/1ps

module qpot_edge #(
   parameter logic IDLE_LEVEL = 1'b0
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset,
   // Level in, edges out
   input  wire logic i_level,
   output logic      o_rise,
   output logic      o_fall
);

   qpot_pkg::qpot_edge_state_t state;
   qpot_pkg::qpot_edge_state_t next_state;

   always_comb
   begin
      next_state.level = i_level;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         state.level <= IDLE_LEVEL;
      else
         state <= next_state;
   end

   assign o_rise = i_level & ~state.level;
   assign o_fall = ~i_level & state.level;

endmodule : qpot_edge

// *** qpot_host_model.sv ***
/* Host model driving the three serial wires.
   Assumes the bench paces it with the system clock. */
`timescale 1ns/1ps
module qpot_host_model (
   // Pacing clock and chain wire
   input  wire logic i_clk,
   input  wire logic i_chain_pin,
   // Serial pins
   output logic      o_serial_clk,
   output logic      o_chip_select_n,
   output logic      o_serial_in
);
   logic [15:0] chain_seen;
   initial
   begin
      o_serial_clk = 1'b0;
      o_chip_select_n = 1'b1;
      o_serial_in = 1'b0;
   end
   // Half period of 3 or more keeps the shift rate legal
   task automatic send(input logic [15:0] bits, input int n, input int half);
      @(negedge i_clk);
      o_chip_select_n = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         o_serial_in = bits[i];
         repeat (half) @(negedge i_clk);
         chain_seen = {chain_seen[14:0], i_chain_pin};
         o_serial_clk = 1'b1;
         repeat (half) @(negedge i_clk);
         o_serial_clk = 1'b0;
      end
      repeat (half) @(negedge i_clk);
      chain_seen = {chain_seen[14:0], i_chain_pin};
      o_chip_select_n = 1'b1;
      // Released data line must not look valid
      o_serial_in = ~o_serial_in;
      repeat (8) @(negedge i_clk);
   endtask : send
endmodule : qpot_host_model

// *** qpot_latch.sv ***
/*
 * One 6-bit wiper latch with asynchronous midscale preset.
 * Assumes i_load is a one-cycle pulse from the frame logic.
 */
`timescale 1ns/1ps
`include "qpot_cfg.svh"

module qpot_latch (
   // Clock and resets
   input  wire logic                i_clk,
   input  wire logic                i_reset,
   input  wire logic                i_midscale_reset_n,
   // Load port
   input  wire logic                i_load,
   input  wire qpot_pkg::qpot_code_t i_code,
   // Held code
   output qpot_pkg::qpot_code_t     o_code
);

   qpot_pkg::qpot_latch_state_t state;
   qpot_pkg::qpot_latch_state_t next_state;

   // Only an addressed load changes the code
   always_comb
   begin
      next_state = state;
      if (i_load)
         next_state.code = i_code;
   end

   // Preset is asynchronous and beats any load
   always_ff @(posedge i_clk or negedge i_midscale_reset_n)
   begin
      if (!i_midscale_reset_n)
         state.code <= `QPOT_MIDSCALE_CODE;
      else if (i_reset)
         state.code <= `QPOT_MIDSCALE_CODE;
      else
         state <= next_state;
   end

   assign o_code = state.code;

endmodule : qpot_latch

// *** qpot_pkg.sv ***
/*
 * Types of the quad wiper serial control block.
 * Assumes qpot_cfg.svh is on the include path.
 */
`include "qpot_cfg.svh"

package qpot_pkg;

   typedef logic [`QPOT_CODE_BITS-1:0] qpot_code_t;
   typedef logic [`QPOT_CHANNELS-1:0][`QPOT_CODE_BITS-1:0] qpot_codes_t;

   // Frame sequence, Gray coded along idle, active, commit
   typedef enum logic [1:0]
   {
      QPOT_IDLE   = 2'h0,
      QPOT_ACTIVE = 2'h1,
      QPOT_COMMIT = 2'h3
   } qpot_frame_e;

   typedef struct packed
   {
      logic rate_err;
      logic align_err;
      logic frame_active;
      logic load_done;
   } qpot_status_t;

   typedef struct packed
   {
      logic level;
   } qpot_edge_state_t;

   typedef struct packed
   {
      qpot_code_t code;
   } qpot_latch_state_t;

   typedef struct packed
   {
      qpot_frame_e                  frame;
      logic [`QPOT_WORD_BITS-1:0]   shift;
      logic [2:0]                   bit_cnt;
      logic                         any_bits;
      logic                         first_edge;
      logic [3:0]                   period_cnt;
      logic                         chain_bit;
      logic                         chain_oe_n;
      logic                         chain_level;
      logic                         load;
      logic [1:0]                   load_addr;
      qpot_code_t                   load_code;
      logic                         hi_open;
      logic                         wiper_low;
      qpot_status_t                 status;
   } qpot_top_state_t;

endpackage : qpot_pkg

// *** qpot_top.sv ***
/*
 * Serial write path of a four-channel, 64-step wiper controller:
 * shift register, frame sequencer, address decode, chain output,
 * shutdown controls and four wiper latches.
 * Assumes the host serial clock, select and data are synchronous
 * inputs sampled at 50 MHz; the analog ladder sits outside.
 */
// Operation
// - One 8-bit word carries one wiper update; host sends one per update.
// - Word is two address bits then six code bits, MSB first.
// - Code bits B5..B0 go to channel twice upper plus lower address plus one.
// - Channels update singly in any order; others keep their codes.
// - Serial clock up to 10 MHz, a 100 ns period.
// - Midscale reset low loads code 32 into all wiper latches.
// - Power down low opens high ends and ties wipers to low ends.
// - Power down keeps latches; settings resume afterward.
// - Each channel holds a 6-bit code selecting one of 64 taps.
// - Code zero is the low end tap; each step moves toward high end.
// - Chip select rising decodes address and loads addressed latch.
// - While select low, each rising serial clock shifts one bit in.
// - Chain output presents the bit entered eight shifts earlier.
// - During power down the open-drain chain output is released.
`timescale 1ns/1ps
`include "qpot_cfg.svh"

module qpot_top (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_reset,
   // Host serial pins
   input  wire logic                  i_serial_clk,
   input  wire logic                  i_chip_select_n,
   input  wire logic                  i_serial_in,
   // Control pins
   input  wire logic                  i_midscale_reset_n,
   input  wire logic                  i_power_down_n,
   // Open-drain chain output
   output logic                       o_serial_chain_out,
   output logic                       o_serial_chain_out_oe_n,
   // Wiper codes, 0 at low end, 63 at high end
   output qpot_pkg::qpot_codes_t      o_wiper_code,
   // Analog switch controls
   output logic                       o_high_end_open,
   output logic                       o_wiper_to_low_end,
   // Status
   output qpot_pkg::qpot_status_t     o_status
);

   localparam logic [3:0] MIN_CYCLES =
      4'(`QPOT_SCLK_MIN_CYCLES);
   localparam logic [3:0] CNT_MAX = 4'hf;

   qpot_pkg::qpot_top_state_t state;
   qpot_pkg::qpot_top_state_t next_state;

   logic       sclk_rise;
   logic       cs_fall;
   logic       cs_rise;
   // Frame events decoded ahead of the sequencer
   logic       shift_take;
   logic       rate_too_fast;
   logic       word_misaligned;
   logic       chain_next;
   logic       chain_drive;
   logic [3:0] load_sel;

   // Edge finders on the host clock and select
   qpot_edge #(
      .IDLE_LEVEL (1'b0)
   ) u_sclk_edge (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_level (i_serial_clk),
      .o_rise  (sclk_rise),
      .o_fall  ()
   );

   qpot_edge #(
      .IDLE_LEVEL (1'b1)
   ) u_cs_edge (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_level (i_chip_select_n),
      .o_rise  (cs_rise),
      .o_fall  (cs_fall)
   );

   // Shift gate, rate and alignment judged from the held state
   always_comb
   begin
      // The commit cycle ignores clock edges while the word is decoded
      shift_take = sclk_rise && !i_chip_select_n &&
                   state.frame != qpot_pkg::QPOT_COMMIT;
      // The first edge of a frame has no period to judge
      rate_too_fast = !state.first_edge &&
                      state.period_cnt < MIN_CYCLES;
      // An empty frame or a part word leaves stale bits in the decode
      word_misaligned = !state.any_bits ||
                        state.bit_cnt != 3'h0;
   end

   // Address decode into one select line per latch
   always_comb
   begin
      case (state.load_addr)
         2'h0:    load_sel = 4'h1;
         2'h1:    load_sel = 4'h2;
         2'h2:    load_sel = 4'h4;
         2'h3:    load_sel = 4'h8;
         default: load_sel = 4'h0;
      endcase
   end

   // Outgoing chain bit and pin drive
   always_comb
   begin
      chain_next = state.chain_bit;
      if (shift_take)
         chain_next = state.shift[`QPOT_WORD_BITS-1];
      // Released when deselected or powered down, sparing the pull-up
      chain_drive = i_power_down_n && !i_chip_select_n &&
                    !chain_next;
   end

   // Four wiper latches, one per address
   genvar ch;
   generate
      for (ch = 0; ch < `QPOT_CHANNELS; ch++)
      begin : g_latch
         logic load_this;
         // Address n selects channel n+1, counted from one
         assign load_this = state.load & load_sel[ch];
         qpot_latch u_latch (
            .i_clk              (i_clk),
            .i_reset            (i_reset),
            .i_midscale_reset_n (i_midscale_reset_n),
            .i_load             (load_this),
            .i_code             (state.load_code),
            .o_code             (o_wiper_code[ch])
         );
      end
   endgenerate

   always_comb
   begin
      next_state = state;
      next_state.load = 1'b0;
      next_state.status.load_done = 1'b0;

      // Period counter saturates so long gaps never wrap
      if (state.period_cnt != CNT_MAX)
         next_state.period_cnt = state.period_cnt + 4'h1;

      case (state.frame)
         qpot_pkg::QPOT_IDLE:
         begin
            if (cs_fall)
            begin
               next_state.frame = qpot_pkg::QPOT_ACTIVE;
               next_state.bit_cnt = 3'h0;
               next_state.any_bits = 1'b0;
               next_state.first_edge = 1'b1;
               next_state.status.rate_err = 1'b0;
               next_state.status.align_err = 1'b0;
            end
         end
         qpot_pkg::QPOT_ACTIVE:
         begin
            if (cs_rise)
            begin
               next_state.frame = qpot_pkg::QPOT_COMMIT;
            end
         end
         qpot_pkg::QPOT_COMMIT:
         begin
            // Last eight bits held decide the target and the code
            next_state.frame = qpot_pkg::QPOT_IDLE;
            next_state.load = 1'b1;
            next_state.load_addr =
               {state.shift[`QPOT_ADDR_HI_POS],
                state.shift[`QPOT_ADDR_LO_POS]};
            next_state.load_code =
               state.shift[`QPOT_CODE_MSB_POS:0];
            next_state.status.load_done = 1'b1;
            // A frame not a whole number of words is flagged
            if (word_misaligned)
               next_state.status.align_err = 1'b1;
         end
         default:
         begin
            next_state.frame = qpot_pkg::QPOT_IDLE;
         end
      endcase

      // Shift on rising serial clock while selected
      if (shift_take)
      begin
         next_state.chain_bit = chain_next;
         next_state.shift =
            {state.shift[`QPOT_WORD_BITS-2:0], i_serial_in};
         next_state.bit_cnt = state.bit_cnt + 3'h1;
         next_state.any_bits = 1'b1;
         next_state.first_edge = 1'b0;
         next_state.period_cnt = 4'h1;
         // Edges closer than the fastest period are flagged
         if (rate_too_fast)
            next_state.status.rate_err = 1'b1;
      end

      next_state.status.frame_active =
         next_state.frame != qpot_pkg::QPOT_IDLE;

      // Shutdown drives switches and releases the chain output; latches are not touched
      next_state.hi_open = ~i_power_down_n;
      next_state.wiper_low = ~i_power_down_n;

      // Open drain: pull low for a zero, release otherwise
      next_state.chain_level = 1'b0;
      next_state.chain_oe_n = ~chain_drive;
   end

   // Midscale reset clears the chain bit and drops a pending load
   always_ff @(posedge i_clk or negedge i_midscale_reset_n)
   begin
      if (!i_midscale_reset_n)
      begin
         state.frame <= qpot_pkg::QPOT_IDLE;
         state.shift <= `QPOT_WORD_RESET;
         state.bit_cnt <= 3'h0;
         state.any_bits <= 1'b0;
         state.first_edge <= 1'b1;
         state.period_cnt <= 4'hf;
         state.chain_bit <= 1'b0;
         state.chain_oe_n <= 1'b1;
         state.chain_level <= 1'b0;
         state.load <= 1'b0;
         state.load_addr <= 2'h0;
         state.load_code <= `QPOT_MIDSCALE_CODE;
         state.hi_open <= 1'b0;
         state.wiper_low <= 1'b0;
         state.status <= '0;
      end
      else if (i_reset)
      begin
         state.frame <= qpot_pkg::QPOT_IDLE;
         state.shift <= `QPOT_WORD_RESET;
         state.bit_cnt <= 3'h0;
         state.any_bits <= 1'b0;
         state.first_edge <= 1'b1;
         state.period_cnt <= 4'hf;
         state.chain_bit <= 1'b0;
         state.chain_oe_n <= 1'b1;
         state.chain_level <= 1'b0;
         state.load <= 1'b0;
         state.load_addr <= 2'h0;
         state.load_code <= `QPOT_MIDSCALE_CODE;
         state.hi_open <= 1'b0;
         state.wiper_low <= 1'b0;
         state.status <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign o_serial_chain_out = state.chain_level;
   assign o_serial_chain_out_oe_n = state.chain_oe_n;
   assign o_high_end_open = state.hi_open;
   assign o_wiper_to_low_end = state.wiper_low;
   assign o_status = state.status;

endmodule : qpot_top

// *** qpot_top_properties.sv ***
/* Checker for the wiper serial block, bound to qpot_top.
   Assumes one clock domain and the hand-over timing. */
`timescale 1ns/1ps
module qpot_top_properties (
   // Clock and reset
   input wire logic                   i_clk,
   input wire logic                   i_reset,
   // Inputs
   input wire logic                   i_serial_clk,
   input wire logic                   i_chip_select_n,
   input wire logic                   i_serial_in,
   input wire logic                   i_midscale_reset_n,
   input wire logic                   i_power_down_n,
   // Outputs
   input wire logic                   o_serial_chain_out_oe_n,
   input wire qpot_pkg::qpot_codes_t  o_wiper_code,
   input wire logic                   o_high_end_open,
   input wire logic                   o_wiper_to_low_end,
   input wire qpot_pkg::qpot_status_t o_status
);
   logic       sclk_q;
   logic [7:0] sr;
   // Own copy of the word, to judge the decode
   always_ff @(posedge i_clk)
   begin
      sclk_q <= i_serial_clk;
      if (!i_chip_select_n && i_serial_clk && !sclk_q)
      begin
         sr <= {sr[6:0], i_serial_in};
      end
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   AST_MIDSCALE:
      assert property (!i_midscale_reset_n |-> o_wiper_code == {4{6'h20}})
      else $error("codes not midscale");
   AST_CODE_CAUSE:
      assert property ($changed(o_wiper_code) && i_midscale_reset_n
         |-> o_status.load_done || $past(o_status.load_done))
      else $error("code changed without load");
   AST_LOAD_CODE:
      assert property (o_status.load_done && i_midscale_reset_n
         |-> ##[0:1] o_wiper_code[sr[7:6]] == sr[5:0])
      else $error("wrong channel or code");
   AST_LOAD_FOLLOWS:
      assert property ($rose(i_chip_select_n) && o_status.frame_active
         && i_midscale_reset_n |-> ##[1:5] o_status.load_done)
      else $error("no load after select");
   AST_SHUT_SWITCH:
      assert property (!i_power_down_n |=> o_high_end_open
         && o_wiper_to_low_end)
      else $error("switches not in shutdown");
   AST_WAKE:
      assert property (i_power_down_n |=> !o_high_end_open
         && !o_wiper_to_low_end)
      else $error("switches stuck after shutdown");
   AST_CHAIN_OFF:
      assert property (!i_power_down_n |=> o_serial_chain_out_oe_n)
      else $error("chain driven in shutdown");
   AST_CHAIN_IDLE:
      assert property (i_chip_select_n [*2] |=> o_serial_chain_out_oe_n)
      else $error("chain driven while idle");
   cover property (o_status.load_done);
   cover property (o_high_end_open);
   cover property (!i_midscale_reset_n [*2]);
endmodule : qpot_top_properties

bind qpot_top qpot_top_properties qpot_top_properties_inst (
   .i_clk, .i_reset, .i_serial_clk, .i_chip_select_n, .i_serial_in,
   .i_midscale_reset_n, .i_power_down_n, .o_serial_chain_out_oe_n,
   .o_wiper_code, .o_high_end_open, .o_wiper_to_low_end, .o_status);

// *** tb_quad_pot_serial_latch_ctrl.sv ***
/* Self-checking bench for qpot_top with a host model.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
module tb_quad_pot_serial_latch_ctrl;
   typedef struct packed
   {
      logic [7:0]           word;
      logic [1:0]           chan;
      qpot_pkg::qpot_code_t code;
   } qpot_row_t;
   localparam qpot_row_t ROWS [8] = '{{8'h3f, 2'h0, 6'h3f},
      {8'h40, 2'h1, 6'h00}, {8'ha5, 2'h2, 6'h25}, {8'hc1, 2'h3, 6'h01},
      {8'h80, 2'h2, 6'h00}, {8'hff, 2'h3, 6'h3f}, {8'h7e, 2'h1, 6'h3e},
      {8'h00, 2'h0, 6'h00}};
   logic                   i_clk;
   logic                   i_reset;
   logic                   i_midscale_reset_n;
   logic                   i_power_down_n;
   logic                   sclk;
   logic                   cs_n;
   logic                   serial_in;
   logic                   chain_out;
   logic                   chain_oe_n;
   logic                   chain_pin;
   logic                   hi_open;
   logic                   to_low;
   qpot_pkg::qpot_codes_t  codes;
   qpot_pkg::qpot_codes_t  exp_codes;
   qpot_pkg::qpot_status_t status;
   int                     mismatches = 0;
   int                     n_tests = 0;
   int                     cycles = 0;
   // Pull-up on the open-drain chain wire
   assign chain_pin = chain_oe_n ? 1'b1 : chain_out;
   qpot_top qpot_top_inst (.i_clk(i_clk), .i_reset(i_reset),
      .i_serial_clk(sclk), .i_chip_select_n(cs_n), .i_serial_in(serial_in),
      .i_midscale_reset_n(i_midscale_reset_n),
      .i_power_down_n(i_power_down_n), .o_serial_chain_out(chain_out),
      .o_serial_chain_out_oe_n(chain_oe_n), .o_wiper_code(codes),
      .o_high_end_open(hi_open), .o_wiper_to_low_end(to_low),
      .o_status(status));
   qpot_host_model qpot_host_model_inst (.i_clk(i_clk),
      .i_chain_pin(chain_pin), .o_serial_clk(sclk),
      .o_chip_select_n(cs_n), .o_serial_in(serial_in));
   task automatic chk_codes(input string what,
      input qpot_pkg::qpot_codes_t exp, input qpot_pkg::qpot_codes_t got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask : chk_codes
   task automatic chk_val(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask : chk_val
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end
   initial
   begin
      i_reset = 1'b1;
      i_midscale_reset_n = 1'b1;
      i_power_down_n = 1'b1;
      exp_codes = {4{6'h20}};
      repeat (10) @(negedge i_clk);
      i_reset = 1'b0;
      @(negedge i_clk);
      chk_codes("reset codes", exp_codes, codes);
      chk_val("reset pins", 8'h04, {5'h0, chain_oe_n, hi_open, to_low});
      foreach (ROWS[i])
      begin
         qpot_host_model_inst.send({8'h0, ROWS[i].word}, 8, 3 + 4 * (i % 2));
         exp_codes[ROWS[i].chan] = ROWS[i].code;
         chk_codes("row codes", exp_codes, codes);
      end
      // Too fast a clock still loads, but flags the rate
      qpot_host_model_inst.send(16'h008a, 8, 2);
      exp_codes[2] = 6'h0a;
      chk_codes("fast codes", exp_codes, codes);
      chk_val("fast status", 8'h08, {4'h0, status});
      // Half a word: older bits fill the decode, alignment flagged
      qpot_host_model_inst.send(16'h000b, 4, 3);
      exp_codes[2] = 6'h2b;
      chk_codes("short codes", exp_codes, codes);
      chk_val("short status", 8'h04, {4'h0, status});
      // Two words in one frame: last one loads, first one leaves
      qpot_host_model_inst.send(16'h9a5c, 16, 3);
      exp_codes[1] = 6'h1c;
      chk_codes("chained codes", exp_codes, codes);
      chk_val("chain out", 8'h9a, qpot_host_model_inst.chain_seen[7:0]);
      i_power_down_n = 1'b0;
      // Rewrites channel 0 with its own value, so codes stay put
      qpot_host_model_inst.send(16'h0000, 16, 3);
      chk_val("shut pins", 8'h07, {5'h0, chain_oe_n, hi_open, to_low});
      chk_val("shut chain", 8'hff, qpot_host_model_inst.chain_seen[7:0]);
      i_power_down_n = 1'b1;
      repeat (3) @(negedge i_clk);
      chk_val("wake pins", 8'h04, {5'h0, chain_oe_n, hi_open, to_low});
      chk_codes("wake codes", exp_codes, codes);
      fork
         qpot_host_model_inst.send(16'h00ff, 8, 3);
         begin
            repeat (45) @(negedge i_clk);
            i_midscale_reset_n = 1'b0;
            repeat (15) @(negedge i_clk);
            chk_codes("midscale", {4{6'h20}}, codes);
            i_midscale_reset_n = 1'b1;
         end
      join
      // Let any stray load surface before judging the override
      repeat (5) @(negedge i_clk);
      chk_codes("override", {4{6'h20}}, codes);
      tally_and_finish();
   end
endmodule : tb_quad_pot_serial_latch_ctrl
